// ### hw/lccr_pkg.sv
package lccr_pkg;

  // Header byte layout within the block's first word
  localparam logic [1:0] LCCR_OFS_IDENT = 2'h0;  // Block identifier byte
  localparam logic [1:0] LCCR_OFS_NEXT = 2'h1;   // Next block link byte
  localparam logic [1:0] LCCR_OFS_CMD = 2'h2;    // Command register, two bytes
  localparam int LCCR_BE_CMD_LO = 2;             // Byte lane of command bits 7:0
  localparam int LCCR_BE_CMD_HI = 3;             // Byte lane of command bits 15:8

  // Block kind field and codes
  localparam int LCCR_KIND_LSB = 13;
  localparam logic [2:0] LCCR_KIND_SLAVE = 3'h0;  // Slave or primary form
  localparam logic [2:0] LCCR_KIND_HOST = 3'h1;   // Host or secondary form
  // Five-bit codes used by other capability blocks
  localparam logic [4:0] LCCR_KIND5_SWITCH = 5'h08;
  localparam logic [4:0] LCCR_KIND5_REVISION = 5'h11;
  localparam logic [4:0] LCCR_KIND5_POWER = 5'h1C;
  localparam logic [4:0] LCCR_KIND5_RSV_A_LO = 5'h09;
  localparam logic [4:0] LCCR_KIND5_RSV_A_HI = 5'h0F;
  localparam logic [4:0] LCCR_KIND5_RSV_B_LO = 5'h1D;
  localparam logic [4:0] LCCR_KIND5_RSV_B_HI = 5'h1F;

  // Slave form fields
  localparam int LCCR_S_TAG_LSB = 0;     // lowest_node_tag 4:0
  localparam int LCCR_S_QTY_LSB = 5;     // tag_quantity 9:5
  localparam int LCCR_S_HPATH_BIT = 10;  // host_path_link
  localparam int LCCR_S_ROUTE_BIT = 11;  // request_route_sense
  // Host form fields
  localparam int LCCR_H_SOFT_BIT = 0;    // soft_reset_choice
  localparam int LCCR_H_TWIN_BIT = 1;    // twin_bridge_flag
  localparam int LCCR_H_DEV_LSB = 2;     // device number 6:2
  localparam int LCCR_H_ORIG_BIT = 7;    // access_origin
  localparam int LCCR_H_HIDE_BIT = 8;    // conceal_host_config
  localparam int LCCR_H_LEAF_BIT = 10;   // host_as_leaf
  localparam int LCCR_H_FERR_BIT = 11;   // far_host_terminal_error
  // Shared field
  localparam int LCCR_DISCARD_BIT = 12;  // discard_when_untrained

  localparam int LCCR_TAG_W = 5;
  localparam logic [4:0] LCCR_TAG_ZERO = 5'h00;
  localparam logic [7:0] LCCR_NEXT_LAST = 8'h00;

  // Power good to link reset release delay after a cold downstream reset
  localparam int LCCR_CLK_PERIOD_NS = 10;
  localparam int LCCR_PWR_TO_RST_US = 1000;
  localparam int LCCR_PWR_TO_RST_CYC = (LCCR_PWR_TO_RST_US * 1000) / LCCR_CLK_PERIOD_NS;
  localparam int LCCR_CNT_W = 17;

  // Outgoing packet disposition
  typedef enum logic [1:0] {
    LCCR_ACT_IDLE,
    LCCR_ACT_FORWARD,
    LCCR_ACT_REJECT,
    LCCR_ACT_STALL
  } lccr_act_e;

  // Downstream reset sequencer states
  typedef enum logic [1:0] {
    LCCR_RS_RUN,
    LCCR_RS_HELD,
    LCCR_RS_PWR_WAIT
  } lccr_rst_e;

  // One configuration access to the block's first word
  typedef struct packed {
    logic valid;          // Access strobe, one cycle
    logic write;          // 1 write, 0 read
    logic [3:0] be;       // Byte enables
    logic [31:0] wdata;   // Write data
    logic link;           // Link number that carried the access
    logic from_chain;     // Access came from the attached chain
  } lccr_cfg_req_s;

endpackage

// ### hw/lccr_top.sv
// Summary of operation
// - Identifier byte reads a fixed block code
// - Next link byte points onward, zero if last
// - Undefined command bits read zero, ignore writes
// - Kind field reads 000 slave, 001 host
// - Other blocks use five-bit kind codes
// - Lowest node tag writable, warm reset clears
// - Lowest tag fills, matches outgoing and incoming tags
// - Tag quantity read-only, highest tag derived
// - Host path captures writing link, warm clears
// - Route sense picks request direction, warm clears
// - Untrained, unterminated link stalls its packets, rejects them if discard set
// - Disposition: terminated rejects, trained forwards, else
// - Hosts may add an initialisation timeout counter
// - Soft reset choice; cold sequence drops power good
// - Twin bridge flag is pure scratch
// - Device number, cold clear, chain tag for leaf
// - Access origin shows inside or chain access
// - Conceal makes chain config accesses end-of-chain
// - Host as leaf applies after warm reset
// - Far host terminal error sets, write one clears
// - Host form bit twelve is discard too
// - Link trained only after rx and tx done
// - Downstream bus reset asserts link reset line, host form only
// - Write-one-clear fields stay readable
`timescale 1ns/1ns
`default_nettype none

module lccr_top #(
  parameter bit HOST_BLOCK = 1'b0,                   // Host form when set
  parameter bit DOUBLE_HOST = 1'b1,                  // Chain-side access supported
  parameter logic [7:0] BLOCK_CODE = 8'h5A,          // Arbitrary value
  parameter logic [7:0] NEXT_LINK = 8'h00,           // Next block, zero when last
  parameter logic [4:0] TAG_QTY = 5'h01,             // Node tags the device needs
  parameter int PWR_TO_RST_CYC = lccr_pkg::LCCR_PWR_TO_RST_CYC  // Shorten in simulation
) (
  input wire logic i_clk,
  input wire logic i_reset,                          // Cold reset
  input wire logic i_clk_en,
  input wire logic i_warm_reset,                     // Warm reset, one or more cycles
  input wire lccr_pkg::lccr_cfg_req_s i_cfg,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,
  output logic o_cfg_as_end_of_chain,
  input wire logic i_rx_init_done,
  input wire logic i_tx_init_done,
  input wire logic i_link_terminated,
  input wire logic i_pkt_valid,
  output lccr_pkg::lccr_act_e o_pkt_action,
  input wire logic [4:0] i_tag_probe,
  output logic o_tag_hit,
  output logic [4:0] o_node_tag,
  output logic o_bridge_marker,
  output logic o_host_path_link,
  output logic o_request_route_sense,
  output logic o_link_trained,
  input wire logic i_far_end_error,
  input wire logic i_downstream_bus_reset,
  output logic o_link_reset_line_n,
  output logic o_power_good_line
);
  import lccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Command state
  logic [4:0] tag_base_r;        // lowest_node_tag
  logic hpath_r;                 // host_path_link
  logic route_r;                 // request_route_sense
  logic discard_r;               // discard_when_untrained, cold only
  logic soft_r;                  // soft_reset_choice
  logic twin_r;                  // twin_bridge_flag
  logic [4:0] devnum_r;          // Device number
  logic hide_r;                  // conceal_host_config
  logic leaf_r;                  // host_as_leaf as written
  logic leaf_live_r;             // host_as_leaf in force
  logic ferr_r;                  // far_host_terminal_error
  logic trained_r;               // link_trained
  logic soft_lat_r;              // Choice held for the running sequence
  logic bus_rst_q_r;             // Previous downstream reset level
  lccr_rst_e rs_r;
  logic [LCCR_CNT_W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire cfg_wr = i_cfg.valid && i_cfg.write;
  wire wr_lo = cfg_wr && i_cfg.be[LCCR_BE_CMD_LO];
  wire wr_hi = cfg_wr && i_cfg.be[LCCR_BE_CMD_HI];
  wire cmd_wr = wr_lo || wr_hi;
  wire [15:0] wcmd = i_cfg.wdata[31:16];
  wire [2:0] kind = HOST_BLOCK ? LCCR_KIND_HOST : LCCR_KIND_SLAVE;
  // Bit 12 is the same discard control in both forms
  wire discard_nxt = wr_hi ? wcmd[LCCR_DISCARD_BIT] : discard_r;
  wire ferr_clr = wr_hi && wcmd[LCCR_H_FERR_BIT];
  // Hardware set beats a simultaneous write-one clear
  wire ferr_nxt = HOST_BLOCK && (i_far_end_error || (ferr_r && !ferr_clr));
  wire hide_rd = DOUBLE_HOST ? hide_r : 1'b1;
  wire orig_rd = DOUBLE_HOST ? i_cfg.from_chain : 1'b0;

  // Slave layout; undefined bits stay zero
  wire [15:0] cmd_slave = {kind, discard_r, route_r, hpath_r, TAG_QTY, tag_base_r};
  // Host layout; bit 9 and unset bits zero
  wire [15:0] cmd_host = {kind, discard_r, ferr_r, leaf_r, 1'b0, hide_rd, orig_rd,
                          devnum_r, twin_r, soft_r};
  wire [15:0] cmd_rd = HOST_BLOCK ? cmd_host : cmd_slave;
  wire [31:0] rdata_nxt = {cmd_rd, NEXT_LINK, BLOCK_CODE};

  // Node tag owned by this end
  wire [4:0] tag_lo = HOST_BLOCK ? (leaf_live_r ? devnum_r : LCCR_TAG_ZERO) : tag_base_r;
  wire [4:0] tag_cnt = HOST_BLOCK ? 5'h01 : TAG_QTY;
  wire [5:0] tag_top = 6'({1'b0, tag_lo} + {1'b0, tag_cnt});  // One past the highest tag
  wire tag_hit_nxt = (i_tag_probe >= tag_lo) && ({1'b0, i_tag_probe} < tag_top);

  // Packet disposition, terminated first
  wire trained_nxt = i_rx_init_done && i_tx_init_done;
  lccr_act_e act_nxt;
  assign act_nxt = !i_pkt_valid ? LCCR_ACT_IDLE :
                   i_link_terminated ? LCCR_ACT_REJECT :
                   trained_r ? LCCR_ACT_FORWARD :
                   discard_r ? LCCR_ACT_REJECT : LCCR_ACT_STALL;

  // Reset sequencer decode
  wire bus_rst_rise = i_downstream_bus_reset && !bus_rst_q_r;
  wire bus_rst_fall = !i_downstream_bus_reset && bus_rst_q_r;
  wire wait_done = cnt_r == LCCR_CNT_W'(PWR_TO_RST_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Cold-only fields
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      discard_r <= 1'b0;
      devnum_r <= LCCR_TAG_ZERO;
      leaf_r <= 1'b0;
      ferr_r <= 1'b0;
    end else if (i_clk_en) begin
      discard_r <= discard_nxt;
      ferr_r <= ferr_nxt;
      if (HOST_BLOCK && wr_lo) begin
        devnum_r <= wcmd[LCCR_H_DEV_LSB +: LCCR_TAG_W];
      end
      if (HOST_BLOCK && DOUBLE_HOST && wr_hi) begin
        leaf_r <= wcmd[LCCR_H_LEAF_BIT];
      end
    end
  end

  // Warm-reset fields
  always_ff @(posedge i_clk) begin
    if (i_reset || (i_warm_reset && i_clk_en)) begin
      tag_base_r <= LCCR_TAG_ZERO;
      hpath_r <= 1'b0;
      route_r <= 1'b0;
      soft_r <= 1'b1;
      twin_r <= 1'b0;
      hide_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!HOST_BLOCK && wr_lo) begin
        tag_base_r <= wcmd[LCCR_S_TAG_LSB +: LCCR_TAG_W];
      end
      // In the slave form, any command write records the link it came in on
      if (!HOST_BLOCK && cmd_wr) begin
        hpath_r <= i_cfg.link;
      end
      if (!HOST_BLOCK && wr_hi) begin
        route_r <= wcmd[LCCR_S_ROUTE_BIT];
      end
      if (HOST_BLOCK && wr_lo) begin
        soft_r <= wcmd[LCCR_H_SOFT_BIT];
        twin_r <= DOUBLE_HOST && wcmd[LCCR_H_TWIN_BIT];
      end
      if (HOST_BLOCK && DOUBLE_HOST && wr_hi) begin
        hide_r <= wcmd[LCCR_H_HIDE_BIT];
      end
    end
  end

  // Leaf mode goes live only at a warm reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      leaf_live_r <= 1'b0;
    end else if (i_clk_en && i_warm_reset) begin
      leaf_live_r <= leaf_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access answer, tag match, disposition
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cfg_rdata <= 32'h0;
      o_cfg_ack <= 1'b0;
      o_cfg_as_end_of_chain <= 1'b0;
      o_tag_hit <= 1'b0;
      o_pkt_action <= LCCR_ACT_IDLE;
      trained_r <= 1'b0;
      o_node_tag <= LCCR_TAG_ZERO;
      o_bridge_marker <= HOST_BLOCK;  // Leaf mode is off after cold reset
    end else if (i_clk_en) begin
      o_cfg_ack <= i_cfg.valid;
      // Read data is the word as it stood before this access
      o_cfg_rdata <= (i_cfg.valid && !i_cfg.write) ? rdata_nxt : 32'h0;
      o_cfg_as_end_of_chain <= i_cfg.valid && HOST_BLOCK && i_cfg.from_chain && hide_rd;
      o_tag_hit <= tag_hit_nxt;
      o_pkt_action <= act_nxt;
      trained_r <= i_warm_reset ? 1'b0 : trained_nxt;
      // Registered copies, so the pins never glitch on a tag change
      o_node_tag <= tag_lo;
      o_bridge_marker <= HOST_BLOCK && !leaf_live_r;
    end
  end

  assign o_host_path_link = hpath_r;
  assign o_request_route_sense = route_r;
  assign o_link_trained = trained_r;

  ////////////////////////////////////////////////////////////////////////
  // Downstream reset sequencer. Software owns the warm release timing;
  // a cold release waits out the power good settling time here.
  // No link initialisation timeout is kept; the host system owns it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rs_r <= LCCR_RS_RUN;
      cnt_r <= '0;
      soft_lat_r <= 1'b1;
      bus_rst_q_r <= 1'b0;
      o_link_reset_line_n <= 1'b1;
      o_power_good_line <= 1'b1;
    end else if (i_clk_en) begin
      bus_rst_q_r <= i_downstream_bus_reset;
      case (rs_r)
        LCCR_RS_RUN: begin
          if (HOST_BLOCK && bus_rst_rise) begin
            rs_r <= LCCR_RS_HELD;
            soft_lat_r <= soft_r;
            o_link_reset_line_n <= 1'b0;
            o_power_good_line <= soft_r;
          end
        end
        LCCR_RS_HELD: begin
          if (bus_rst_fall) begin
            o_power_good_line <= 1'b1;
            cnt_r <= '0;
            if (soft_lat_r) begin
              rs_r <= LCCR_RS_RUN;
              o_link_reset_line_n <= 1'b1;
            end else begin
              rs_r <= LCCR_RS_PWR_WAIT;
            end
          end
        end
        LCCR_RS_PWR_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (wait_done) begin
            rs_r <= LCCR_RS_RUN;
            o_link_reset_line_n <= 1'b1;
          end
        end
        default: begin
          rs_r <= LCCR_RS_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_read_word;
    i_clk_en && i_cfg.valid && !i_cfg.write |=> o_cfg_ack &&
      o_cfg_rdata[7:0] == BLOCK_CODE && o_cfg_rdata[15:8] == NEXT_LINK &&
      o_cfg_rdata[31:29] == kind;
  endproperty
  a_read_word: assert property (p_read_word) else $error("header word wrong");

  // Host layout has one hole, just above the conceal bit
  property p_rsv_zero;
    i_clk_en && i_cfg.valid && !i_cfg.write && HOST_BLOCK |=>
      o_cfg_rdata[LCCR_BE_CMD_LO * 8 + LCCR_H_HIDE_BIT + 1] == 1'b0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");

  property p_hpath;
    i_clk_en && !i_warm_reset && cmd_wr && !HOST_BLOCK |=> hpath_r == $past(i_cfg.link);
  endproperty
  a_hpath: assert property (p_hpath) else $error("host path not captured");

  property p_warm;
    i_clk_en && i_warm_reset |=> tag_base_r == LCCR_TAG_ZERO && !route_r && soft_r && !hide_r;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset values wrong");

  property p_discard_keep;
    i_clk_en && i_warm_reset && !cmd_wr |=> discard_r == $past(discard_r);
  endproperty
  a_discard_keep: assert property (p_discard_keep) else $error("discard lost on warm");

  property p_disp;
    i_clk_en && i_pkt_valid && !i_link_terminated && !trained_r |=>
      o_pkt_action == ($past(discard_r) ? LCCR_ACT_REJECT : LCCR_ACT_STALL);
  endproperty
  a_disp: assert property (p_disp) else $error("untrained disposition wrong");

  property p_term;
    i_clk_en && i_pkt_valid && i_link_terminated |=> o_pkt_action == LCCR_ACT_REJECT;
  endproperty
  a_term: assert property (p_term) else $error("terminated not rejected");

  property p_ferr_set;
    i_clk_en && HOST_BLOCK && i_far_end_error |=> ferr_r;
  endproperty
  a_ferr_set: assert property (p_ferr_set) else $error("error set lost");

  property p_trained;
    i_clk_en && o_link_trained |-> $past(i_rx_init_done) && $past(i_tx_init_done);
  endproperty
  a_trained: assert property (p_trained) else $error("trained too early");

  property p_bus_rst;
    i_clk_en && HOST_BLOCK && rs_r == LCCR_RS_RUN && bus_rst_rise |=>
      !o_link_reset_line_n && o_power_good_line == $past(soft_r);
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset not driven");

  property p_hide;
    i_clk_en && HOST_BLOCK && i_cfg.valid && i_cfg.from_chain && hide_rd |=> o_cfg_as_end_of_chain;
  endproperty
  a_hide: assert property (p_hide) else $error("conceal ignored");

  // A primary or secondary block must never read as another block's code
  property p_kind_code;
    i_clk_en && i_cfg.valid && !i_cfg.write |=>
      o_cfg_rdata[31:29] != LCCR_KIND5_SWITCH[4:2] &&
      o_cfg_rdata[31:29] != LCCR_KIND5_REVISION[4:2] &&
      o_cfg_rdata[31:29] != LCCR_KIND5_POWER[4:2];
  endproperty
  a_kind_code: assert property (p_kind_code) else $error("kind aliases another block");

  // Leaf mode moves only at a warm reset
  property p_leaf_live;
    i_clk_en |=>
      leaf_live_r == ($past(i_warm_reset) ? $past(leaf_r) : $past(leaf_live_r));
  endproperty
  a_leaf_live: assert property (p_leaf_live) else $error("leaf mode changed early");

  c_stall: cover property (o_pkt_action == LCCR_ACT_STALL ##1 o_pkt_action == LCCR_ACT_FORWARD);
  c_cold_seq: cover property (rs_r == LCCR_RS_PWR_WAIT ##1 rs_r == LCCR_RS_RUN);
  c_ferr_clr: cover property (ferr_r ##1 !ferr_r);
  c_tag_hit: cover property (o_tag_hit && o_node_tag != LCCR_TAG_ZERO);

endmodule // lccr_top

`default_nettype wire

// ### test/lccr_cfg_model.sv
`timescale 1ns/1ns
`default_nettype none

// Configuration requester standing in for host or chain software
module lccr_cfg_model (
  input wire logic i_clk,
  output lccr_pkg::lccr_cfg_req_s o_cfg
);
  import lccr_pkg::*;

  initial o_cfg = '0;  // Idle before the first request

  // One access, strobed for a single edge, then an idle gap of at least one cycle
  task automatic access(input logic wr, input logic [3:0] be, input logic [31:0] d,
      input logic lnk, input logic ch, input int gap);
    o_cfg <= '{valid: 1'b1, write: wr, be: be, wdata: d, link: lnk, from_chain: ch};
    @(posedge i_clk);
    // Released lines show the inverse, never a stale copy
    o_cfg <= '{valid: 1'b0, write: ~wr, be: ~be, wdata: ~d, link: ~lnk, from_chain: ~ch};
    repeat (gap) @(posedge i_clk);
  endtask
endmodule  // lccr_cfg_model

`default_nettype wire

// ### test/lccr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none

module lccr_top_bench;
  import lccr_pkg::*;
  localparam int PWR = 8;  // Short power-good to reset delay
  localparam logic [4:0] QTY = 5'h03;
  localparam logic [7:0] IDENT = 8'h5A;  // Arbitrary value
  localparam logic [7:0] NEXT = 8'h44;
  typedef struct packed {logic [31:0] d; logic e;} lccr_exp_s;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_warm_reset = 1'b0;
  logic rx_done = 1'b0, tx_done = 1'b0, term = 1'b0, pkt_valid = 1'b0;
  logic far_err = 1'b0, bus_rst = 1'b0, clk_en = 1'b1;
  logic [4:0] probe = 5'h00;
  lccr_cfg_req_s cfg;
  logic [31:0] rdata [2];
  logic ack [2], eoc [2], hit [2], bmark [2], hpath [2], route [2], trained [2];
  logic rst_n [2], pgood [2];
  lccr_act_e act [2];
  logic [4:0] ntag [2];
  lccr_exp_s exp_q [2][$];  // Notes per form, oldest first
  logic [15:0] sw [2];  // Writable bits as software last left them
  logic hp, ferr, leaf;
  int num_errors = 0, num_checks = 0, seed = 80912;

  always #5 i_clk = ~i_clk;

  lccr_cfg_model PM (.i_clk(i_clk), .o_cfg(cfg));

  // Slave form at index 0, host form at index 1, same stimulus
  for (genvar g = 0; g < 2; g++) begin : g_form
    lccr_top #(.HOST_BLOCK(g == 1), .BLOCK_CODE(IDENT), .NEXT_LINK(NEXT), .TAG_QTY(QTY),
        .PWR_TO_RST_CYC(PWR)) DUT (
      .i_clk(i_clk), .i_reset(i_reset), .i_clk_en(clk_en), .i_warm_reset(i_warm_reset),
      .i_cfg(cfg), .o_cfg_rdata(rdata[g]), .o_cfg_ack(ack[g]), .o_cfg_as_end_of_chain(eoc[g]),
      .i_rx_init_done(rx_done), .i_tx_init_done(tx_done), .i_link_terminated(term),
      .i_pkt_valid(pkt_valid), .o_pkt_action(act[g]), .i_tag_probe(probe), .o_tag_hit(hit[g]),
      .o_node_tag(ntag[g]), .o_bridge_marker(bmark[g]), .o_host_path_link(hpath[g]),
      .o_request_route_sense(route[g]), .o_link_trained(trained[g]),
      .i_far_end_error(far_err), .i_downstream_bus_reset(bus_rst),
      .o_link_reset_line_n(rst_n[g]), .o_power_good_line(pgood[g]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Command word as each form should present it
  function automatic logic [15:0] cmd_of(input int g, input logic orig);
    if (g == 0) return {3'b000, sw[0][12:11], hp, QTY, sw[0][4:0]};
    return {3'b001, sw[1][12], ferr, sw[1][10], 1'b0, sw[1][8], orig, sw[1][6:0]};
  endfunction

  // Note the expected answer first, then hand the access to the requester
  task automatic acc(input logic wr, input logic [3:0] be, input logic [31:0] d,
      input logic lnk, input logic ch);
    lccr_exp_s e;
    for (int g = 0; g < 2; g++) begin
      e.d = wr ? 32'h0 : {cmd_of(g, ch), NEXT, IDENT};
      e.e = (g == 1) && ch && sw[1][8];
      exp_q[g].push_back(e);
    end
    if (wr && (be[2] || be[3])) begin
      hp = lnk;
      for (int g = 0; g < 2; g++) begin
        if (be[2]) sw[g][7:0] = d[23:16];
        if (be[3]) sw[g][15:8] = d[31:24];
      end
      if (be[3] && d[27]) ferr = 1'b0;
    end
    PM.access(wr, be, d, lnk, ch, 1 + ($random(seed) & 1));
  endtask

  task automatic cold();
    i_reset <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    sw[0] = 16'h0000;
    sw[1] = 16'h0001;
    {hp, ferr, leaf} = 3'b000;
  endtask

  task automatic warm();
    i_warm_reset <= 1'b1;
    @(posedge i_clk);
    i_warm_reset <= 1'b0;
    {sw[0][11], sw[0][4:0], hp} = 7'h00;
    {sw[1][8], sw[1][1], sw[1][0]} = 3'b001;
    leaf = sw[1][10];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Each answer takes the oldest note of its form
  always @(posedge i_clk) begin
    lccr_exp_s e;
    for (int g = 0; g < 2; g++) begin
      if (ack[g] === 1'b1) begin
        if (exp_q[g].size() == 0) begin
          check(32'h1, 32'h0);
        end else begin
          e = exp_q[g].pop_front();
          check(rdata[g], e.d);
          check(eoc[g], e.e);
        end
      end
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] t;
    logic [3:0] be_tab [3] = '{4'h4, 4'h8, 4'hC};
    int n;
    cold();
    acc(0, 4'h0, 32'h0, 0, 1);
    acc(0, 4'h0, 32'h0, 0, 0);
    acc(1, 4'hF, 32'hFFFFFFFF, 1, 0);
    acc(0, 4'h0, 32'h0, 0, 0);
    check(ntag[1], 5'h00);
    check(bmark[1], 1'b1);
    acc(1, 4'h0, 32'h0, 0, 1);
    acc(1, 4'h3, 32'h0000FFFF, 0, 0);
    warm();
    acc(0, 4'h0, 32'h0, 0, 0);
    check(ntag[1], 5'h1F);
    check(bmark[1], 1'b0);
    check(bmark[0], 1'b0);
    // Random partial writes, each read back
    for (int i = 0; i < 6; i++) begin
      acc(1, be_tab[$unsigned($random(seed)) % 3], $random(seed), 1'($random(seed)), 0);
      acc(0, 4'h0, 32'h0, 0, 0);
      check(hpath[0], hp);
      check(route[0], sw[0][11]);
    end
    // Owned tag range, both edges of it
    t = 5'($unsigned($random(seed)) % 29);
    acc(1, 4'h4, {8'h00, 3'b000, t, 16'h0000}, 0, 0);
    for (int k = 0; k < 6; k++) begin
      probe <= (k < 2) ? t + QTY - 5'h01 + 5'(k) : (k == 2) ? t : 5'($random(seed));
      repeat (2) @(posedge i_clk);
      check(ntag[0], t);
      check(hit[0], probe >= t && probe <= t + QTY - 5'h01);
      check(hit[1], probe == (leaf ? sw[1][6:2] : 5'h00));
    end
    // Every row of the disposition table
    for (int i = 0; i < 16; i++) begin
      acc(1, 4'h8, {3'b000, i[3], 28'h0}, 0, 0);
      {tx_done, rx_done, term} <= i[2:0];
      pkt_valid <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int g = 0; g < 2; g++) begin
        check(trained[g], i[1] & i[2]);
        check(act[g], i[0] ? LCCR_ACT_REJECT : (i[1] & i[2]) ? LCCR_ACT_FORWARD :
            i[3] ? LCCR_ACT_REJECT : LCCR_ACT_STALL);
      end
    end
    pkt_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    check(act[0], LCCR_ACT_IDLE);
    // Clock enable low freezes the disposition output
    clk_en <= 1'b0;
    pkt_valid <= 1'b1;
    repeat (3) @(posedge i_clk);
    check(act[1], LCCR_ACT_IDLE);
    clk_en <= 1'b1;
    pkt_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    // Far host error sets, then a one written clears it
    far_err <= 1'b1;
    @(posedge i_clk);
    far_err <= 1'b0;
    ferr = 1'b1;
    acc(0, 4'h0, 32'h0, 0, 0);
    acc(1, 4'h8, 32'h08000000, 0, 0);
    acc(0, 4'h0, 32'h0, 0, 0);
    // Downstream reset, warm choice then cold choice; choice held steady meanwhile
    for (int s = 1; s >= 0; s--) begin
      acc(1, 4'h4, {15'h0000, s[0], 16'h0000}, 0, 0);
      bus_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      check(rst_n[1], 1'b0);
      check(pgood[1], s[0]);
      check(rst_n[0] & pgood[0], 1'b1);
      repeat (3) @(posedge i_clk);
      bus_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      check(pgood[1], 1'b1);
      n = 0;
      while (rst_n[1] !== 1'b1 && n < 20) begin
        @(posedge i_clk);
        n++;
      end
      check(s ? (n == 0) : (n >= PWR - 3 && n <= PWR + 1), 1'b1);
    end
    // Second cold reset in mid-run
    cold();
    acc(0, 4'h0, 32'h0, 0, 0);
    repeat (4) @(posedge i_clk);
    check(exp_q[0].size() + exp_q[1].size(), 0);
    stop_test();
  end
endmodule  // lccr_top_bench

`default_nettype wire
